// ### core/i2c_master_rs.sv
`timescale 1ns/1ps
// Behaviour
// - Master only with master mode and enable
// - Hardware drives and releases both bus lines
// - Start/stop seen cleared on reset, disable
// - Six operations, requested one at a time
// - No queueing; early buffer write sets collision
// - Interrupt flag on every completed event
// - Repeated start begins by pulling clock low
// - Clock low: load generator, release data
// - Timeout, data high: release clock; reload once clock seen high
// - Data low one period, clear request, hold
// - Start seen set on detected start
// - Repeated start interrupt after final timeout
// - Repeated start request ignored while busy
// - Collision: data low or clock falls early
// - Buffer write during sequence sets collision
// - Low five request bits locked while busy
// - Bus collision aborts, flags, returns idle
module i2c_master_rs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Open-drain bus lines
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  // Address match, used by read, write and error decode
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    regHit = (a == off);
  endfunction

  logic [3:0] mode_q, mode_d;
  logic enable_q, enable_d, write_collision_flag_q, write_collision_flag_d, ackData_q, ackData_d, ackStat_q, ackStat_d;
  logic [i2c_mrs_pkg::REQ_W-1:0] req_q, req_d;
  logic startSeen_q, startSeen_d, stopSeen_q, stopSeen_d, full_q, full_d;
  logic [7:0] buf_q, buf_d;
  logic [6:0] reload_q, reload_d, brg_q, brg_d;
  logic irq_q, irq_d, bcol_q, bcol_d;
  i2c_mrs_pkg::seq_t seq_q, seq_d;
  logic [2:0] ph_q, ph_d;
  logic [3:0] bits_q, bits_d;
  logic [1:0] kind_q, kind_d;
  logic [8:0] shift_q, shift_d;
  logic sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, sclPrev_q, sdaPrev_q;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, pslverr_d;
  logic masterOn, busy, wrEn, rdEn, brgZero, brgLoad, doneEv, bcolEv, startDet, stopDet;

  // Bus strobes; writes land in the access cycle where pready is high
  assign wrEn = psel && penable && pwrite && pready_q;
  assign rdEn = psel && penable && !pwrite && pready_q;
  assign masterOn = enable_q && (mode_q == i2c_mrs_pkg::MODE_MASTER);
  assign busy = (seq_q != i2c_mrs_pkg::ST_IDLE) || (|req_q);
  assign brgZero = (brg_q == 7'h00);
  // Conditions seen on the wires, judged against last cycle's sample
  assign startDet = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
  assign stopDet = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;

  // Sequencer and register file next state
  always_comb
  begin
    mode_d = mode_q;
    enable_d = enable_q;
    write_collision_flag_d = write_collision_flag_q;
    ackData_d = ackData_q;
    ackStat_d = ackStat_q;
    req_d = req_q;
    startSeen_d = startSeen_q;
    stopSeen_d = stopSeen_q;
    full_d = full_q;
    buf_d = buf_q;
    reload_d = reload_q;
    irq_d = irq_q;
    bcol_d = bcol_q;
    seq_d = seq_q;
    ph_d = ph_q;
    bits_d = bits_q;
    kind_d = kind_q;
    shift_d = shift_q;
    sclOe_d = sclOe_q;
    sdaOe_d = sdaOe_q;
    brgLoad = 1'b0;
    doneEv = 1'b0;
    bcolEv = 1'b0;
    // Software side; clears come first so a same-cycle set below wins
    if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_CTRL1))
    begin
      mode_d = pwdata[i2c_mrs_pkg::MODE_LSB +: i2c_mrs_pkg::MODE_W];
      enable_d = pwdata[i2c_mrs_pkg::ENABLE_BIT];
      write_collision_flag_d = write_collision_flag_q && pwdata[i2c_mrs_pkg::WRITE_COLLISION_FLAG_BIT];
    end
    if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_CTRL2))
    begin
      ackData_d = pwdata[i2c_mrs_pkg::ACKDATA_BIT];
      if (!busy && masterOn)
        req_d = pwdata[i2c_mrs_pkg::REQ_W-1:0];
    end
    if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_RELOAD))
      reload_d = pwdata[i2c_mrs_pkg::RELOAD_W-1:0];
    if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_FLAGS))
    begin
      irq_d = irq_q && !pwdata[i2c_mrs_pkg::IRQ_BIT];
      bcol_d = bcol_q && !pwdata[i2c_mrs_pkg::BCOL_BIT];
    end
    if (rdEn && regHit(paddr, i2c_mrs_pkg::ADDR_BUF))
      full_d = 1'b0;
    // Baud generator counts down to zero and holds there unless reloaded below
    if (!brgZero)
      brg_d = brg_q - 7'h01;
    else
      brg_d = brg_q;
    case (seq_q)
      i2c_mrs_pkg::ST_IDLE:
      begin
        ph_d = 3'h0;
        if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_BUF))
        begin
          if (busy || !masterOn)
            write_collision_flag_d = 1'b1;
          else
          begin
            buf_d = pwdata[7:0];
            full_d = 1'b1;
            shift_d = {pwdata[7:0], 1'b1};
            kind_d = i2c_mrs_pkg::KIND_TX;
            bits_d = i2c_mrs_pkg::BITS_TX;
            seq_d = i2c_mrs_pkg::ST_XFER;
          end
        end
        else if (req_q[i2c_mrs_pkg::START_BIT])
          seq_d = i2c_mrs_pkg::ST_START;
        else if (req_q[i2c_mrs_pkg::RSTART_BIT])
          seq_d = i2c_mrs_pkg::ST_RSTART;
        else if (req_q[i2c_mrs_pkg::STOP_BIT])
          seq_d = i2c_mrs_pkg::ST_STOP;
        else if (req_q[i2c_mrs_pkg::RECV_BIT])
        begin
          shift_d = 9'h1FF;
          kind_d = i2c_mrs_pkg::KIND_RX;
          bits_d = i2c_mrs_pkg::BITS_RX;
          seq_d = i2c_mrs_pkg::ST_XFER;
        end
        else if (req_q[i2c_mrs_pkg::ACK_BIT])
        begin
          shift_d = {ackData_q, 8'hFF};
          kind_d = i2c_mrs_pkg::KIND_ACK;
          bits_d = i2c_mrs_pkg::BITS_ACK;
          seq_d = i2c_mrs_pkg::ST_XFER;
        end
      end
      i2c_mrs_pkg::ST_START:
      begin
        case (ph_q)
          3'h0:
          begin
            if (!sdaIn || !sclIn)
              bcolEv = 1'b1;
            else
            begin
              sclOe_d = 1'b0;
              sdaOe_d = 1'b0;
              brgLoad = 1'b1;
              ph_d = 3'h1;
            end
          end
          3'h1:
          begin
            if (brgZero)
            begin
              sdaOe_d = 1'b1;
              brgLoad = 1'b1;
              ph_d = 3'h2;
            end
          end
          default:
          begin
            if (brgZero)
            begin
              sclOe_d = 1'b1;
              req_d[i2c_mrs_pkg::START_BIT] = 1'b0;
              doneEv = 1'b1;
            end
          end
        endcase
      end
      i2c_mrs_pkg::ST_RSTART:
      begin
        case (ph_q)
          3'h0:
          begin
            sclOe_d = 1'b1;
            if (!sclIn && sclOe_q)
            begin
              sdaOe_d = 1'b0;
              brgLoad = 1'b1;
              ph_d = 3'h1;
            end
          end
          3'h1:
          begin
            if (brgZero && sdaIn)
            begin
              sclOe_d = 1'b0;
              ph_d = 3'h2;
            end
            else if (brgZero)
              bcolEv = 1'b1;
          end
          3'h2:
          begin
            if (sclIn && !sdaIn)
              bcolEv = 1'b1;
            else if (sclIn)
            begin
              brgLoad = 1'b1;
              ph_d = 3'h3;
            end
          end
          3'h3:
          begin
            if (!sclIn || !sdaIn)
              bcolEv = 1'b1;
            else if (brgZero)
            begin
              sdaOe_d = 1'b1;
              brgLoad = 1'b1;
              ph_d = 3'h4;
            end
          end
          default:
          begin
            // No reload here: the data line stays low for the next step
            if (brgZero)
            begin
              req_d[i2c_mrs_pkg::RSTART_BIT] = 1'b0;
              doneEv = 1'b1;
            end
          end
        endcase
      end
      i2c_mrs_pkg::ST_XFER:
      begin
        case (ph_q)
          3'h0:
          begin
            // Clock low, present the bit; a one is a released line
            sclOe_d = 1'b1;
            sdaOe_d = !shift_q[8];
            brgLoad = 1'b1;
            ph_d = 3'h1;
          end
          3'h1:
          begin
            if (brgZero)
            begin
              sclOe_d = 1'b0;
              ph_d = 3'h2;
            end
          end
          3'h2:
          begin
            // Wait here while a slave stretches the clock
            if (sclIn)
            begin
              brgLoad = 1'b1;
              ph_d = 3'h3;
            end
          end
          default:
          begin
            if (brgZero)
            begin
              shift_d = {shift_q[7:0], sdaIn};
              sclOe_d = 1'b1;
              bits_d = bits_q - 4'h1;
              ph_d = 3'h0;
              if (bits_q == 4'h1)
              begin
                doneEv = 1'b1;
                sdaOe_d = 1'b0;
                if (kind_q == i2c_mrs_pkg::KIND_TX)
                begin
                  ackStat_d = sdaIn;
                  full_d = 1'b0;
                end
                else if (kind_q == i2c_mrs_pkg::KIND_RX)
                begin
                  buf_d = shift_d[7:0];
                  full_d = 1'b1;
                  req_d[i2c_mrs_pkg::RECV_BIT] = 1'b0;
                end
                else
                  req_d[i2c_mrs_pkg::ACK_BIT] = 1'b0;
              end
            end
          end
        endcase
      end
      i2c_mrs_pkg::ST_STOP:
      begin
        case (ph_q)
          3'h0:
          begin
            sclOe_d = 1'b1;
            sdaOe_d = 1'b1;
            brgLoad = 1'b1;
            ph_d = 3'h1;
          end
          3'h1:
          begin
            if (brgZero)
            begin
              sclOe_d = 1'b0;
              ph_d = 3'h2;
            end
          end
          3'h2:
          begin
            if (sclIn)
            begin
              brgLoad = 1'b1;
              ph_d = 3'h3;
            end
          end
          3'h3:
          begin
            if (brgZero)
            begin
              sdaOe_d = 1'b0;
              brgLoad = 1'b1;
              ph_d = 3'h4;
            end
          end
          default:
          begin
            if (brgZero)
            begin
              req_d[i2c_mrs_pkg::STOP_BIT] = 1'b0;
              doneEv = 1'b1;
            end
          end
        endcase
      end
      default:
        seq_d = i2c_mrs_pkg::ST_IDLE;
    endcase
    if (brgLoad)
      brg_d = reload_q;
    if (doneEv)
    begin
      irq_d = 1'b1;
      seq_d = i2c_mrs_pkg::ST_IDLE;
      ph_d = 3'h0;
    end
    // A lost arbitration drops everything and lets go of the wires
    if (bcolEv)
    begin
      bcol_d = 1'b1;
      req_d = '0;
      seq_d = i2c_mrs_pkg::ST_IDLE;
      ph_d = 3'h0;
      sclOe_d = 1'b0;
      sdaOe_d = 1'b0;
    end
    // Buffer writes while a sequence runs are refused
    if (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_BUF) && seq_q != i2c_mrs_pkg::ST_IDLE)
      write_collision_flag_d = 1'b1;
    // Bus condition detector; seen flags follow the wires
    if (stopDet)
    begin
      stopSeen_d = 1'b1;
      startSeen_d = 1'b0;
    end
    if (startDet)
    begin
      startSeen_d = 1'b1;
      stopSeen_d = 1'b0;
    end
    if (!enable_q)
    begin
      startSeen_d = 1'b0;
      stopSeen_d = 1'b0;
    end
    // Leaving master operation hands the bus back at once
    if (!masterOn)
    begin
      seq_d = i2c_mrs_pkg::ST_IDLE;
      ph_d = 3'h0;
      req_d = '0;
      sclOe_d = 1'b0;
      sdaOe_d = 1'b0;
    end
  end

  // APB read path, registered so outputs come from flops
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      if (regHit(paddr, i2c_mrs_pkg::ADDR_CTRL1))
        prdata_d = {24'h00_0000, write_collision_flag_q, 1'b0, enable_q, 1'b0, mode_q};
      else if (regHit(paddr, i2c_mrs_pkg::ADDR_CTRL2))
        prdata_d = {25'h000_0000, ackStat_q, ackData_q, req_q};
      else if (regHit(paddr, i2c_mrs_pkg::ADDR_STATUS))
        prdata_d = {27'h000_0000, stopSeen_q, startSeen_q, busy, 1'b0, full_q};
      else if (regHit(paddr, i2c_mrs_pkg::ADDR_BUF))
        prdata_d = {24'h00_0000, buf_q};
      else if (regHit(paddr, i2c_mrs_pkg::ADDR_RELOAD))
        prdata_d = {25'h000_0000, reload_q};
      else if (regHit(paddr, i2c_mrs_pkg::ADDR_FLAGS))
        prdata_d = {30'h0000_0000, bcol_q, irq_q};
      else
        pslverr_d = 1'b1;
    end
  end

  // All state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= i2c_mrs_pkg::MODE_RESET;
      enable_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ackData_q <= 1'b0;
      ackStat_q <= 1'b0;
      req_q <= '0;
      startSeen_q <= 1'b0;
      stopSeen_q <= 1'b0;
      full_q <= 1'b0;
      buf_q <= 8'h00;
      reload_q <= i2c_mrs_pkg::RELOAD_RESET;
      brg_q <= 7'h00;
      irq_q <= 1'b0;
      bcol_q <= 1'b0;
      seq_q <= i2c_mrs_pkg::ST_IDLE;
      ph_q <= 3'h0;
      bits_q <= 4'h0;
      kind_q <= i2c_mrs_pkg::KIND_TX;
      shift_q <= 9'h1FF;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      enable_q <= enable_d;
      write_collision_flag_q <= write_collision_flag_d;
      ackData_q <= ackData_d;
      ackStat_q <= ackStat_d;
      req_q <= req_d;
      startSeen_q <= startSeen_d;
      stopSeen_q <= stopSeen_d;
      full_q <= full_d;
      buf_q <= buf_d;
      reload_q <= reload_d;
      brg_q <= brg_d;
      irq_q <= irq_d;
      bcol_q <= bcol_d;
      seq_q <= seq_d;
      ph_q <= ph_d;
      bits_q <= bits_d;
      kind_q <= kind_d;
      shift_q <= shift_d;
      sclOe_q <= sclOe_d;
      sdaOe_q <= sdaOe_d;
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
      prdata_q <= prdata_d;
      pready_q <= psel && !penable;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sclOe = sclOe_q;
  assign sdaOe = sdaOe_q;
  assign sclOut = 1'b0; // Open drain: the low level is the only one driven
  assign sdaOut = 1'b0;

  // Checks beside the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_master_gate: assert property (!masterOn |=> seq_q == i2c_mrs_pkg::ST_IDLE && !sclOe_q && !sdaOe_q)
    else $error("sequencer active outside master operation");
  a_seen_clear: assert property (!enable_q |=> !startSeen_q && !stopSeen_q)
    else $error("seen flags not cleared while disabled");
  a_write_collision_flag_refuse: assert property (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_BUF) && busy
    |=> write_collision_flag_q && buf_q == $past(buf_q))
    else $error("buffer write while busy was not refused");
  a_rs_clock_low: assert property (seq_q == i2c_mrs_pkg::ST_RSTART && ph_q == 3'h0 && masterOn |=> sclOe_q)
    else $error("repeated start did not pull clock low");
  a_rs_release: assert property (seq_q == i2c_mrs_pkg::ST_RSTART && ph_q == 3'h1 && brgZero && sdaIn
    && masterOn |=> !sclOe_q && ph_q == 3'h2)
    else $error("clock not released at timeout");
  a_rs_finish: assert property (seq_q == i2c_mrs_pkg::ST_RSTART && ph_q == 3'h4 && brgZero && masterOn
    |=> irq_q && !req_q[i2c_mrs_pkg::RSTART_BIT] && sdaOe_q && seq_q == i2c_mrs_pkg::ST_IDLE)
    else $error("repeated start did not finish correctly");
  a_rs_collide: assert property (seq_q == i2c_mrs_pkg::ST_RSTART && ph_q == 3'h3 && !sclIn && masterOn
    |=> bcol_q && seq_q == i2c_mrs_pkg::ST_IDLE && !sclOe_q)
    else $error("early clock fall not flagged");
  a_req_locked: assert property (wrEn && regHit(paddr, i2c_mrs_pkg::ADDR_CTRL2) && busy && !doneEv && !bcolEv
    && masterOn |=> req_q == $past(req_q))
    else $error("request bits written while busy");
  a_start_seen: assert property (startDet && enable_q |=> startSeen_q)
    else $error("start condition not recorded");
  a_baud_count: assert property (!brgZero && !brgLoad ##1 1'b1 |-> brg_q == $past(brg_q) - 7'h01)
    else $error("baud generator did not count down");
  a_event_irq: assert property (doneEv && !bcolEv && masterOn |=> irq_q)
    else $error("completed event did not raise interrupt flag");
  c_start_done: cover property (seq_q == i2c_mrs_pkg::ST_START && doneEv);
  c_rstart_done: cover property (seq_q == i2c_mrs_pkg::ST_RSTART && doneEv);
  c_tx_done: cover property (seq_q == i2c_mrs_pkg::ST_XFER && kind_q == i2c_mrs_pkg::KIND_TX && doneEv);
  c_collision: cover property (bcolEv);
endmodule // i2c_master_rs

// ### core/i2c_mrs_pkg.sv
package i2c_mrs_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BUF = 8'h0C;
  localparam logic [7:0] ADDR_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  // First control register fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int ENABLE_BIT = 5;
  localparam int WRITE_COLLISION_FLAG_BIT = 7;
  // Second control register fields; the low five are sequence requests
  localparam int REQ_W = 5;
  localparam int START_BIT = 0;
  localparam int RSTART_BIT = 1;
  localparam int STOP_BIT = 2;
  localparam int RECV_BIT = 3;
  localparam int ACK_BIT = 4;
  localparam int ACKDATA_BIT = 5;
  localparam int ACKSTAT_BIT = 6;
  // Status register fields
  localparam int FULL_BIT = 0;
  localparam int BUSY_BIT = 2;
  localparam int STARTSEEN_BIT = 3;
  localparam int STOPSEEN_BIT = 4;
  // Flag register fields, write one to clear
  localparam int IRQ_BIT = 0;
  localparam int BCOL_BIT = 1;
  // Baud generator
  localparam int RELOAD_W = 7;
  localparam logic [6:0] RELOAD_RESET = 7'h09;
  // Transfer kinds and bit counts
  localparam logic [1:0] KIND_TX = 2'h0;
  localparam logic [1:0] KIND_RX = 2'h1;
  localparam logic [1:0] KIND_ACK = 2'h2;
  localparam logic [3:0] BITS_TX = 4'h9;
  localparam logic [3:0] BITS_RX = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h1;
  typedef enum {ST_IDLE, ST_START, ST_RSTART, ST_XFER, ST_STOP} seq_t;
endpackage

// ### testbench/i2c_bus_model.sv
`timescale 1ns/1ps
// Open-drain bus with pull-ups and a simple slave that can acknowledge and stretch
module i2c_bus_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Master line enables
  input wire logic sclOe,
  input wire logic sdaOe,
  // Behaviour controls from the bench
  input wire logic ackEn,
  input wire logic stretch,
  input wire logic jamSda,
  input wire logic jamScl,
  // Resolved lines and last byte seen
  output logic sclIn,
  output logic sdaIn,
  output logic [7:0] rxByte
);
  logic sclQ, sdaQ, oeQ, ackQ;
  logic [3:0] bitCnt;
  logic [1:0] hold;
  // Pull-ups win only when nobody pulls low; oeQ term avoids a one-cycle high glitch
  assign sclIn = !(sclOe || hold != 2'h0 || (stretch && oeQ) || jamScl);
  assign sdaIn = !(sdaOe || ackQ || jamSda);
  // Track line edges; a start condition restarts byte framing
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {sclQ, sdaQ, oeQ, ackQ} <= 4'hC;
      bitCnt <= 4'h0;
      hold <= 2'h0;
      rxByte <= 8'h00;
    end
    else
    begin
      sclQ <= sclIn;
      sdaQ <= sdaIn;
      oeQ <= sclOe;
      // A slow slave keeps the clock low a while after the master lets go
      if (stretch && oeQ && !sclOe)
        hold <= 2'h3;
      else if (hold != 2'h0)
        hold <= hold - 2'h1;
      if (sclQ && sclIn && sdaQ && !sdaIn)
        bitCnt <= 4'h0;
      else if (!sclQ && sclIn)
      begin
        bitCnt <= bitCnt + 4'h1;
        if (bitCnt < 4'h8)
          rxByte <= {rxByte[6:0], sdaIn};  // MSB first
      end
      else if (sclQ && !sclIn && bitCnt == 4'h8)
        ackQ <= ackEn;
      else if (sclQ && !sclIn && bitCnt == 4'h9)
      begin
        ackQ <= 1'b0;
        bitCnt <= 4'h0;
      end
    end
endmodule  // i2c_bus_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, onVal;
  logic pready, pslverr, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe;
  logic ackEn = 1'b1;
  logic stretch = 1'b0;
  logic jamSda = 1'b0;
  logic jamScl = 1'b0;
  logic [7:0] rxByte, txVal;
  logic [64:0] expQ[$];  // Notes of {error, mask, value}
  int num_errors = 0;
  int n_compared = 0;
  time t0, tFlag;
  // Clock at 20 MHz
  always #25 clk = ~clk;
  i2c_master_rs i2c_master_rs_i (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
  i2c_bus_model i2c_bus_model_i (.clk(clk), .rst(rst), .sclOe(sclOe), .sdaOe(sdaOe), .ackEn(ackEn),
    .stretch(stretch), .jamSda(jamSda), .jamScl(jamScl), .sclIn(sclIn), .sdaIn(sdaIn), .rxByte(rxByte));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Watcher: each finished access takes the oldest note
  always @(posedge clk)
    if (psel && penable && pready)
    begin : cmp
      logic [64:0] e;
      e = expQ.pop_front();
      check({31'h0, pslverr}, {31'h0, e[64]});
      if (!pwrite)
        check(prdata & e[63:32], e[31:0]);
    end
  // One APB transfer; one idle cycle before setup keeps each signal to one change per edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m,
    input logic [31:0] x, input logic e);
    int n;
    expQ.push_back({e, m, x});
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // A slave that never answers is a failure, not a silent skip
    if (pready !== 1'b1)
      num_errors++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, m, x, 1'b0);
  endtask
  // Poll a flag under a bound, note it set, then clear it
  task automatic waitFlag(input int b);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 400)
    begin
      rdx(i2c_mrs_pkg::ADDR_FLAGS, 32'h0, 32'h0);
      n++;
    end
    tFlag = $time;
    rdx(i2c_mrs_pkg::ADDR_FLAGS, 32'h1 << b, 32'h1 << b);
    wr(i2c_mrs_pkg::ADDR_FLAGS, 32'h1 << b);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog sized well above the whole sequence
  initial
  begin
    #(50 * 30000);
    num_errors++;
    stop_test();
  end
  initial
  begin
    void'($urandom(71438));
    onVal = 32'(i2c_mrs_pkg::MODE_MASTER) | (32'h1 << i2c_mrs_pkg::ENABLE_BIT);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped offset
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'hFF, 32'h0);
    rdx(i2c_mrs_pkg::ADDR_STATUS, 32'h1D, 32'h0);
    rdx(i2c_mrs_pkg::ADDR_RELOAD, 32'h7F, 32'(i2c_mrs_pkg::RELOAD_RESET));
    apb(8'h18, 1'b0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(8'h18, 1'b1, 32'h5A, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
    // Not yet master: requests ignored, buffer write collides, flag sticky
    wr(i2c_mrs_pkg::ADDR_CTRL1, 32'h1 << i2c_mrs_pkg::ENABLE_BIT);
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1);
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h1F, 32'h0);
    check({31'h0, sclOe | sdaOe}, 32'h0);
    check({30'h0, sclOut, sdaOut}, 32'h0);
    wr(i2c_mrs_pkg::ADDR_BUF, 32'hA5);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h80, 32'h80);
    wr(i2c_mrs_pkg::ADDR_CTRL1, 32'h80);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h80, 32'h80);
    wr(i2c_mrs_pkg::ADDR_CTRL1, 32'h0);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h80, 32'h0);
    $display("test idle done");
    // Start, then a buffer write that must not queue
    wr(i2c_mrs_pkg::ADDR_RELOAD, 32'h2);
    wr(i2c_mrs_pkg::ADDR_CTRL1, onVal);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h2F, onVal);
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::START_BIT);
    wr(i2c_mrs_pkg::ADDR_BUF, 32'h3C);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h80, 32'h80);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    rdx(i2c_mrs_pkg::ADDR_STATUS, 32'h8, 32'h8);
    wr(i2c_mrs_pkg::ADDR_CTRL1, onVal);
    // Random byte to a stretching slave, then one that is not acknowledged
    txVal = 8'($urandom());
    stretch <= 1'b1;
    wr(i2c_mrs_pkg::ADDR_BUF, {24'h0, txVal});
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    check({24'h0, rxByte}, {24'h0, txVal});
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h40, 32'h0);
    stretch <= 1'b0;
    ackEn <= 1'b0;
    wr(i2c_mrs_pkg::ADDR_BUF, {24'h0, ~txVal});
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h40, 32'h40);
    ackEn <= 1'b1;
    $display("test start and transmit done");
    // Repeated start with blocked requests and a colliding buffer write
    wr(i2c_mrs_pkg::ADDR_RELOAD, 32'h6);
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::RSTART_BIT);
    t0 = $time;
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h5);
    wr(i2c_mrs_pkg::ADDR_BUF, 32'h77);
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h1F, 32'h2);
    rdx(i2c_mrs_pkg::ADDR_CTRL1, 32'h80, 32'h80);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    // Three baud periods of seven cycles pass before the flag may be seen
    check({31'h0, (tFlag - t0) > 21 * 50}, 32'h1);
    check({30'h0, sclIn, sdaIn}, 32'h2);
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h1F, 32'h0);
    rdx(i2c_mrs_pkg::ADDR_STATUS, 32'h8, 32'h8);
    wr(i2c_mrs_pkg::ADDR_CTRL1, onVal);
    wr(i2c_mrs_pkg::ADDR_BUF, 32'hA0);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    check({24'h0, rxByte}, 32'hA0);
    $display("test repeated start done");
    // Receive from a silent slave, send a not-acknowledge, then stop
    ackEn <= 1'b0;
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::RECV_BIT);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    rdx(i2c_mrs_pkg::ADDR_BUF, 32'hFF, 32'hFF);
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h30);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::STOP_BIT);
    waitFlag(i2c_mrs_pkg::IRQ_BIT);
    rdx(i2c_mrs_pkg::ADDR_STATUS, 32'h10, 32'h10);
    check({30'h0, sclOe, sdaOe}, 32'h0);
    ackEn <= 1'b1;
    $display("test receive and stop done");
    // Data line held low by another party during a repeated start
    jamSda <= 1'b1;
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::RSTART_BIT);
    waitFlag(i2c_mrs_pkg::BCOL_BIT);
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h1F, 32'h0);
    check({30'h0, sclOe, sdaOe}, 32'h0);
    jamSda <= 1'b0;
    // Clock pulled low by another party in the high period before data falls
    wr(i2c_mrs_pkg::ADDR_CTRL2, 32'h1 << i2c_mrs_pkg::RSTART_BIT);
    repeat (13) @(posedge clk);
    jamScl <= 1'b1;
    waitFlag(i2c_mrs_pkg::BCOL_BIT);
    jamScl <= 1'b0;
    rdx(i2c_mrs_pkg::ADDR_CTRL2, 32'h1F, 32'h0);
    check({30'h0, sclOe, sdaOe}, 32'h0);
    // Disable clears the seen flags
    wr(i2c_mrs_pkg::ADDR_CTRL1, 32'h0);
    rdx(i2c_mrs_pkg::ADDR_STATUS, 32'h18, 32'h0);
    $display("test collision and disable done");
    stop_test();
  end
endmodule  // testbench
